// File: rtl/fsac_defs.svh
// Constants for the flash sector access control block.
`ifndef FSAC_DEFS_SVH
`define FSAC_DEFS_SVH
`define FSAC_SIZE_4K 2'h0
`define FSAC_SIZE_8K 2'h1
`define FSAC_SIZE_BIG 2'h2
`define FSAC_SEC0_BASE 16'hf000
`define FSAC_SEC1_BASE 16'he000
`define FSAC_SEC_TOP_BIT 15
`define FSAC_GUARD_KEY1 8'h56
`define FSAC_GUARD_KEY2 8'hae
`define FSAC_FCS_RESET 8'h00
`define FSAC_FCS_PGM_BIT 0
`define FSAC_FCS_ERS_BIT 1
`define FSAC_FCS_MASS_BIT 2
`define FSAC_CMD_WRITE 8'h01
`define FSAC_CMD_READ 8'h02
`define FSAC_CMD_ERASE_SEC 8'h03
`define FSAC_CMD_ERASE_ALL 8'h04
`define FSAC_CMD_OPTION 8'h05
`define FSAC_RO_MASK 8'h00
`define FSAC_OPT_RP_BIT 0
`endif

// File: rtl/fsac_pkg.sv
// Types for the flash sector access control block.
package fsac_pkg;
  typedef enum logic [1:0] {
    FSAC_MODE_APP = 2'b00,
    FSAC_MODE_TOOL = 2'b01,
    FSAC_MODE_ICP = 2'b10,
    FSAC_MODE_TEST = 2'b11
  } fsac_mode_t;

  typedef enum logic [2:0] {
    FSAC_OP_NONE = 3'b000,
    FSAC_OP_PROG = 3'b001,
    FSAC_OP_ERASE_SEC = 3'b010,
    FSAC_OP_ERASE_ALL = 3'b011,
    FSAC_OP_OPTION = 3'b100
  } fsac_op_t;

  typedef struct packed {
    fsac_op_t op;
    logic [15:0] addr;
    logic [7:0] data;
  } fsac_req_t;

  typedef enum logic [1:0] {
    FSAC_RX_CMD = 2'b00,
    FSAC_RX_AHI = 2'b01,
    FSAC_RX_ALO = 2'b10,
    FSAC_RX_DAT = 2'b11
  } fsac_rx_t;
endpackage

// File: rtl/fsac_core.sv
// Flash sector access control with an in-circuit serial link.
`timescale 1ns/100ps
`include "fsac_defs.svh"

module fsac_core
  import fsac_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Link pins; the serial ones clocked by the tool, the other three synchronized to mclk.
  input wire logic incircuit_serial_clock,
  input wire logic incircuit_serial_data_in,
  output logic incircuit_serial_data_out,
  output logic incircuit_serial_data_oe,
  input wire logic programming_voltage_select,
  input wire logic tool_attached,
  input wire logic external_oscillator_in,
  // Device configuration.
  input wire logic [1:0] flash_size,
  input wire logic part_32k,
  // Application side.
  input wire logic app_req_valid,
  input wire fsac_req_t app_req,
  input wire logic [7:0] app_guard_wr,
  input wire logic app_guard_wr_en,
  input wire logic app_pin_out,
  // Flash array port.
  output logic flash_we,
  output logic flash_erase,
  output logic flash_erase_all,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  input wire logic [7:0] flash_rdata,
  // Status.
  output fsac_mode_t mode,
  output logic readout_protected,
  output logic [7:0] flash_control_status,
  output logic app_pin_enable,
  output logic incircuit_test_mode
);

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: shift in command, address and data bytes.
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  fsac_rx_t rx_state;
  fsac_req_t link_word;
  logic link_tog;
  logic [7:0] link_cmd;
  logic [7:0] tx_byte;
  logic tx_active;
  logic [7:0] rd_hold;
  logic rd_phase;
  wire [7:0] shifted = {shift[6:0], incircuit_serial_data_in};
  wire byte_done = (bit_cnt == 3'h7);
  wire cmd_has_data = (link_cmd == `FSAC_CMD_WRITE) || (link_cmd == `FSAC_CMD_OPTION);

  function automatic fsac_op_t cmd_to_op(input logic [7:0] c);
    unique case (c)
      `FSAC_CMD_WRITE: cmd_to_op = FSAC_OP_PROG;
      `FSAC_CMD_ERASE_SEC: cmd_to_op = FSAC_OP_ERASE_SEC;
      `FSAC_CMD_ERASE_ALL: cmd_to_op = FSAC_OP_ERASE_ALL;
      `FSAC_CMD_OPTION: cmd_to_op = FSAC_OP_OPTION;
      default: cmd_to_op = FSAC_OP_NONE;
    endcase
  endfunction

  // The tool owns the link clock; a session idles between bytes and the reset
  // held by the tool clears any partial frame.
  always_ff @(posedge incircuit_serial_clock or negedge reset_n) begin
    if (!reset_n) begin
      shift <= 8'h00;
      bit_cnt <= 3'h0;
      rx_state <= FSAC_RX_CMD;
      link_word <= '0;
      link_tog <= 1'b0;
      link_cmd <= 8'h00;
      rd_phase <= 1'b0;
    end else if (rd_phase) begin
      // Response bits are the device's own; they must not be parsed as a command.
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done)
        rd_phase <= 1'b0;
    end else begin
      shift <= shifted;
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done) begin
        unique case (rx_state)
          FSAC_RX_CMD: begin
            link_cmd <= shifted;
            rx_state <= (shifted == `FSAC_CMD_ERASE_ALL) ? FSAC_RX_CMD : FSAC_RX_AHI;
            if (shifted == `FSAC_CMD_ERASE_ALL) begin
              link_word <= '{op: FSAC_OP_ERASE_ALL, addr: 16'h0000, data: 8'h00};
              link_tog <= ~link_tog;
            end
          end
          FSAC_RX_AHI: begin
            link_word.addr[15:8] <= shifted;
            rx_state <= FSAC_RX_ALO;
          end
          FSAC_RX_ALO: begin
            link_word.addr[7:0] <= shifted;
            link_word.op <= cmd_to_op(link_cmd);
            rx_state <= cmd_has_data ? FSAC_RX_DAT : FSAC_RX_CMD;
            if (!cmd_has_data)
              link_tog <= ~link_tog;
            if (link_cmd == `FSAC_CMD_READ)
              rd_phase <= 1'b1;
          end
          FSAC_RX_DAT: begin
            link_word.data <= shifted;
            rx_state <= FSAC_RX_CMD;
            link_tog <= ~link_tog;
          end
        endcase
      end
    end
  end

  // The response shifts out MSB first on the rising edges of the eight clocks after a read address.
  // The tool samples each bit in the high phase of its clock.
  always_ff @(posedge incircuit_serial_clock or negedge reset_n) begin
    if (!reset_n)
      tx_byte <= 8'h00;
    else if (rd_phase && bit_cnt == 3'h0)
      tx_byte <= rd_hold;
    else if (rd_phase)
      tx_byte <= {tx_byte[6:0], 1'b0};
  end
  // The driver lets go on the falling edge after the last bit, so the next command finds the line free.
  always_ff @(negedge incircuit_serial_clock or negedge reset_n) begin
    if (!reset_n)
      tx_active <= 1'b0;
    else
      tx_active <= rd_phase;
  end
  assign incircuit_serial_data_out = tx_byte[7];
  assign incircuit_serial_data_oe = tx_active;

  //////////////////////////////////////////////////////////////////////////////
  // Crossing into the system domain by toggle; the word is stable by then.
  logic tog_s1, tog_s2, tog_s3;
  logic att_s1, att_s2, vpp_s1, vpp_s2, osc_s1, osc_s2;
  fsac_req_t link_req;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      {tog_s1, tog_s2, tog_s3} <= 3'b000;
      {att_s1, att_s2, vpp_s1, vpp_s2, osc_s1, osc_s2} <= 6'h00;
      link_req <= '0;
    end else begin
      {tog_s1, tog_s2, tog_s3} <= {link_tog, tog_s1, tog_s2};
      {att_s1, att_s2} <= {tool_attached, att_s1};
      {vpp_s1, vpp_s2} <= {programming_voltage_select, vpp_s1};
      {osc_s1, osc_s2} <= {external_oscillator_in, osc_s1};
      if (tog_s2 != tog_s3)
        link_req <= link_word;
    end
  end
  logic link_pulse;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      link_pulse <= 1'b0;
    else
      link_pulse <= (tog_s2 != tog_s3);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode, entry clock check and pin ownership.
  logic osc_seen;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      osc_seen <= 1'b0;
    else if (!att_s2)
      osc_seen <= 1'b0;
    else if (osc_s2)
      osc_seen <= 1'b1;
  end
  wire entry_clock_ok = part_32k || osc_seen;
  wire link_mode = att_s2 && vpp_s2 && entry_clock_ok;
  assign mode = link_mode ? FSAC_MODE_ICP : (att_s2 ? FSAC_MODE_TEST : FSAC_MODE_APP);
  assign incircuit_test_mode = att_s2 && !vpp_s2;
  assign app_pin_enable = !att_s2;

  //////////////////////////////////////////////////////////////////////////////
  // Sector decoding and permission.
  function automatic logic [1:0] sector_of(input logic [15:0] a);
    if (a >= `FSAC_SEC0_BASE)
      sector_of = 2'h0;
    else if (a >= `FSAC_SEC1_BASE)
      sector_of = 2'h1;
    else
      sector_of = 2'h2;
  endfunction

  function automatic logic sector_present(input logic [1:0] s, input logic [1:0] sz);
    sector_present = (s == 2'h0) || (s == 2'h1 && sz != `FSAC_SIZE_4K) || (s == 2'h2 && sz == `FSAC_SIZE_BIG);
  endfunction

  // Guard: two keys written in order arm one operation for the application.
  logic [1:0] guard;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      guard <= 2'h0;
    else if (app_guard_wr_en)
      guard <= (guard == 2'h0 && app_guard_wr == `FSAC_GUARD_KEY1) ? 2'h1 :
               (guard == 2'h1 && app_guard_wr == `FSAC_GUARD_KEY2) ? 2'h2 : 2'h0;
    else if (app_req_valid)
      guard <= 2'h0;
  end

  logic prot_opt;
  wire use_link = link_pulse && link_mode;
  wire fsac_req_t req = use_link ? link_req : app_req;
  wire req_valid = use_link || (app_req_valid && !att_s2 && guard == 2'h2);
  wire [1:0] req_sec = sector_of(req.addr);
  wire sec_ok = sector_present(req_sec, flash_size);
  wire mode_ok = use_link || (req_sec != 2'h0);
  wire opt_ok = use_link;
  wire prog_ok = req_valid && req.op == FSAC_OP_PROG && sec_ok && mode_ok && !prot_opt;
  wire esec_ok = req_valid && req.op == FSAC_OP_ERASE_SEC && sec_ok && mode_ok && !prot_opt;
  wire eall_ok = req_valid && req.op == FSAC_OP_ERASE_ALL && use_link;
  wire unprot = req_valid && req.op == FSAC_OP_OPTION && opt_ok && prot_opt && !req.data[`FSAC_OPT_RP_BIT];
  wire opt_wr = req_valid && req.op == FSAC_OP_OPTION && opt_ok;

  //////////////////////////////////////////////////////////////////////////////
  // Option bit, control status byte and flash strobes.
  logic [7:0] fcs;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prot_opt <= 1'b0;
      fcs <= `FSAC_FCS_RESET;
      flash_we <= 1'b0;
      flash_erase <= 1'b0;
      flash_erase_all <= 1'b0;
      flash_addr <= 16'h0000;
      flash_wdata <= 8'h00;
    end else begin
      if (opt_wr)
        prot_opt <= req.data[`FSAC_OPT_RP_BIT];
      flash_we <= prog_ok;
      flash_erase <= esec_ok;
      flash_erase_all <= eall_ok || unprot;
      if (req_valid)
        flash_addr <= req.addr;
      flash_wdata <= req.data;
      fcs <= 8'h00;
      fcs[`FSAC_FCS_PGM_BIT] <= prog_ok;
      fcs[`FSAC_FCS_ERS_BIT] <= esec_ok;
      fcs[`FSAC_FCS_MASS_BIT] <= eall_ok || unprot;
    end
  end
  assign readout_protected = prot_opt;
  assign flash_control_status = fcs;

  // Read data for the link is masked while protected.
  // The tool leaves several system clocks between a read address and its response,
  // so this word stands still whenever the link samples it.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      rd_hold <= 8'h00;
    else
      rd_hold <= prot_opt ? `FSAC_RO_MASK : flash_rdata;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  AST_SEC0_APP: assert property (@(posedge mclk) disable iff (!reset_n)
    (app_req_valid && !att_s2 && !use_link && sector_of(app_req.addr) == 2'h0) |=> !flash_we && !flash_erase)
    else $error("sector 0 altered from application");
  AST_PROT_WR: assert property (@(posedge mclk) disable iff (!reset_n)
    prot_opt |=> !flash_we) else $error("write while protected");
  AST_PROT_RD: assert property (@(posedge mclk) disable iff (!reset_n)
    prot_opt |=> rd_hold == `FSAC_RO_MASK) else $error("protected read leaked");
  AST_UNPROT: assert property (@(posedge mclk) disable iff (!reset_n)
    $fell(prot_opt) |-> flash_erase_all) else $error("unprotect without mass erase");
  AST_ABSENT: assert property (@(posedge mclk) disable iff (!reset_n)
    (req_valid && !sec_ok) |=> !flash_we && !flash_erase) else $error("absent sector altered");
  // Ownership passes to the tool within two system clocks of it being plugged in.
  AST_PIN: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(tool_attached, 2) |-> !app_pin_enable) else $error("pins given to application");
  AST_GUARD: assert property (@(posedge mclk) disable iff (!reset_n)
    (app_req_valid && guard != 2'h2 && !use_link) |=> !flash_we) else $error("unguarded write");
  AST_FCS: assert property (@(posedge mclk) disable iff (!reset_n)
    flash_we |-> fcs[`FSAC_FCS_PGM_BIT]) else $error("status byte missed program");

  // A frame that asks to program is carried out once, at the word it named.
  sequence s_link_prog;
    use_link && req.op == FSAC_OP_PROG && sec_ok && !prot_opt;
  endsequence
  sequence s_prog_strobe;
    flash_we && fcs[`FSAC_FCS_PGM_BIT] && flash_addr == $past(req.addr, 1) && flash_wdata == $past(req.data, 1);
  endsequence
  AST_LINK_PROG: assert property (@(posedge mclk) disable iff (!reset_n)
    s_link_prog |=> s_prog_strobe)
    else $error("link program not carried out");

  // Removing protection wipes the array in the same step that clears the bit.
  sequence s_unprot_req;
    use_link && req.op == FSAC_OP_OPTION && prot_opt && !req.data[`FSAC_OPT_RP_BIT];
  endsequence
  AST_UNPROT_WIPE: assert property (@(posedge mclk) disable iff (!reset_n)
    s_unprot_req |=> flash_erase_all && !prot_opt)
    else $error("protection dropped without wipe");

  // Whole array erase and the option byte are reachable from the tool only.
  AST_MASS: assert property (@(posedge mclk) disable iff (!reset_n)
    (use_link && req.op == FSAC_OP_ERASE_ALL) |=> flash_erase_all)
    else $error("link mass erase lost");
  AST_APP_NO_MASS: assert property (@(posedge mclk) disable iff (!reset_n)
    (!use_link && app_req_valid && (app_req.op == FSAC_OP_ERASE_ALL || app_req.op == FSAC_OP_OPTION))
    |=> !flash_erase_all && $stable(prot_opt)) else $error("application reached mass erase or option");
  AST_SMALL: assert property (@(posedge mclk) disable iff (!reset_n)
    (req_valid && flash_size == `FSAC_SIZE_4K && req.addr < `FSAC_SEC0_BASE) |=> !flash_we && !flash_erase)
    else $error("missing sector altered on small part");
  AST_SEC0_ERASE: assert property (@(posedge mclk) disable iff (!reset_n)
    (flash_erase && flash_addr >= `FSAC_SEC0_BASE) |-> $past(use_link, 1))
    else $error("vector sector erased by application");
  AST_GUARD_ONCE: assert property (@(posedge mclk) disable iff (!reset_n)
    (app_req_valid && !app_guard_wr_en) |=> guard == 2'h0)
    else $error("guard stayed armed");
  AST_TX_RELEASE: assert property (@(negedge incircuit_serial_clock) disable iff (!reset_n)
    !rd_phase |=> !incircuit_serial_data_oe)
    else $error("link data held after response");
endmodule // fsac_core

// File: tb/fsac_tool_model.sv
// Behavioural programming tool on the in-circuit link.
`timescale 1ns/100ps
module fsac_tool_model (
  // Link pins.
  output logic sclk,
  output logic sdata,
  input wire logic dev_out,
  input wire logic dev_oe
);
  logic drv_en = 1'b0;
  logic drv_bit = 1'b0;
  logic idle_lvl = 1'b1;
  int gap_ns = 0;
  // The line has no pull, so once released it shows the inverse of its last level.
  assign sdata = dev_oe ? dev_out : (drv_en ? drv_bit : idle_lvl);
  initial sclk = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  task automatic send_byte(input logic [7:0] b);
    #(gap_ns);
    drv_en = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      drv_bit = b[i];
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
  endtask
  // Letting go only after the last byte keeps the enable steady between bytes.
  task automatic release_line();
    idle_lvl = ~drv_bit;
    drv_en = 1'b0;
  endtask
  // The clock stands still between frames, so the device sees edges only here and in send_byte.
  task automatic read_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b1;
      #14 b[i] = sdata;
      #1 sclk = 1'b0;
      #15;
    end
    idle_lvl = ~b[0];
  endtask
endmodule // fsac_tool_model

// File: tb/testbench.sv
// Self-checking bench for the flash sector access control block.
`timescale 1ns/100ps
`include "fsac_defs.svh"
module testbench;
  import fsac_pkg::*;
  logic mclk, reset_n, vsel, attached, ext_osc, app_valid, guard_en, part_32k;
  logic sclk, sdata, sd_out, sd_oe, f_we, f_er, f_all, prot, pin_en, test_mode;
  logic [1:0] flash_size;
  logic [7:0] guard_wr, f_wdata, fcs, last_data;
  logic [15:0] f_addr, last_addr;
  fsac_req_t app_req;
  fsac_mode_t mode;
  int error_cnt = 0, n_compared = 0, cycles = 0, n_we = 0, n_er = 0, n_all = 0;
  fsac_tool_model tool (.sclk(sclk), .sdata(sdata), .dev_out(sd_out), .dev_oe(sd_oe));
  fsac_core uut (.mclk(mclk), .reset_n(reset_n), .incircuit_serial_clock(sclk),
    .incircuit_serial_data_in(sdata), .incircuit_serial_data_out(sd_out), .incircuit_serial_data_oe(sd_oe),
    .programming_voltage_select(vsel), .tool_attached(attached), .external_oscillator_in(ext_osc),
    .flash_size(flash_size), .part_32k(part_32k), .app_req_valid(app_valid), .app_req(app_req),
    .app_guard_wr(guard_wr), .app_guard_wr_en(guard_en), .app_pin_out(1'b0), .flash_we(f_we),
    .flash_erase(f_er), .flash_erase_all(f_all), .flash_addr(f_addr), .flash_wdata(f_wdata),
    .flash_rdata(8'h5a), .mode(mode), .readout_protected(prot), .flash_control_status(fcs),
    .app_pin_enable(pin_en), .incircuit_test_mode(test_mode));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (f_we === 1'b1) begin
      n_we++;
      last_addr = f_addr;
      last_data = f_wdata;
    end
    if (f_er === 1'b1) n_er++;
    if (f_all === 1'b1) n_all++;
    if (cycles == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Waiting ten cycles after each frame keeps frames well over the minimum spacing.
  task automatic frame(input logic [7:0] cmd, input logic [15:0] addr, input logic [7:0] data, input bit more);
    tool.send_byte(cmd);
    if (cmd != `FSAC_CMD_ERASE_ALL) tool.send_byte(addr[15:8]);
    if (cmd != `FSAC_CMD_ERASE_ALL) tool.send_byte(addr[7:0]);
    if (more) tool.send_byte(data);
    tool.release_line();
    tick(10);
  endtask
  task automatic app_op(input fsac_op_t op, input logic [15:0] addr, input bit keyed);
    guard_en = keyed;
    guard_wr = `FSAC_GUARD_KEY1;
    tick(1);
    guard_wr = `FSAC_GUARD_KEY2;
    tick(1);
    guard_en = 1'b0;
    app_req = '{op, addr, 8'h3c};
    app_valid = 1'b1;
    tick(1);
    app_valid = 1'b0;
    tick(4);
  endtask
  task automatic enter_link();
    attached = 1'b1;
    vsel = 1'b1;
    ext_osc = 1'b1;
    tick(2);
    ext_osc = 1'b0;
    tick(4);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_link();
    int w = n_we;
    int e = n_er;
    logic [7:0] rd;
    enter_link();
    check_val("mode", FSAC_MODE_ICP, mode);
    check_val("pin_en", 16'h0, pin_en);
    frame(`FSAC_CMD_WRITE, 16'hffff, 8'ha5, 1'b1);
    check_val("we_cnt", w + 1, n_we);
    check_val("we_addr", 16'hffff, last_addr);
    check_val("we_data", 16'h00a5, last_data);
    frame(`FSAC_CMD_ERASE_SEC, 16'hf000, 8'h00, 1'b0);
    frame(`FSAC_CMD_ERASE_SEC, 16'hd000, 8'h00, 1'b0);
    check_val("er_cnt", e + 1, n_er);
    flash_size = `FSAC_SIZE_BIG;
    frame(`FSAC_CMD_ERASE_SEC, 16'hd000, 8'h00, 1'b0);
    check_val("er_big", e + 2, n_er);
    flash_size = `FSAC_SIZE_4K;
    frame(`FSAC_CMD_ERASE_SEC, 16'he000, 8'h00, 1'b0);
    check_val("er_4k", e + 2, n_er);
    flash_size = `FSAC_SIZE_8K;
    frame(`FSAC_CMD_ERASE_ALL, 16'h0000, 8'h00, 1'b0);
    check_val("all_cnt", 16'h1, n_all);
    frame(`FSAC_CMD_READ, 16'hfffe, 8'h00, 1'b0);
    tool.read_byte(rd);
    check_val("rd", 16'h005a, rd);
  endtask
  task automatic t_app();
    int w = n_we;
    int e = n_er;
    attached = 1'b0;
    vsel = 1'b0;
    tick(4);
    app_op(FSAC_OP_PROG, 16'hffff, 1'b1);
    check_val("app_s0", w, n_we);
    app_op(FSAC_OP_PROG, 16'he123, 1'b0);
    check_val("app_nokey", w, n_we);
    app_op(FSAC_OP_PROG, 16'he123, 1'b1);
    check_val("app_we", w + 1, n_we);
    check_val("app_addr", 16'he123, last_addr);
    app_op(FSAC_OP_ERASE_SEC, 16'he000, 1'b1);
    check_val("app_er", e + 1, n_er);
    app_op(FSAC_OP_ERASE_ALL, 16'he000, 1'b1);
    check_val("app_all", 16'h1, n_all);
  endtask
  task automatic t_protect();
    int w = n_we;
    logic [7:0] rd;
    enter_link();
    tool.gap_ns = 200;
    frame(`FSAC_CMD_OPTION, 16'h0000, 8'h01, 1'b1);
    check_val("prot", 16'h1, prot);
    frame(`FSAC_CMD_READ, 16'hfffe, 8'h00, 1'b0);
    tool.read_byte(rd);
    check_val("prot_rd", 16'h0, rd);
    frame(`FSAC_CMD_WRITE, 16'he000, 8'h11, 1'b1);
    check_val("prot_we", w, n_we);
    frame(`FSAC_CMD_OPTION, 16'h0000, 8'h00, 1'b1);
    check_val("unprot_all", 16'h2, n_all);
    check_val("unprot", 16'h0, prot);
    tool.gap_ns = 0;
  endtask
  task automatic t_test_mode();
    vsel = 1'b0;
    tick(4);
    check_val("test_mode", 16'h1, test_mode);
    check_val("mode_test", FSAC_MODE_TEST, mode);
    attached = 1'b0;
    tick(4);
  endtask
  initial begin
    {vsel, attached, ext_osc, app_valid, guard_en, part_32k} = '0;
    flash_size = `FSAC_SIZE_8K;
    guard_wr = 8'h00;
    app_req = '0;
    reset_n = 1'b0;
    repeat (6) @(posedge mclk);
    #1 reset_n = 1'b1;
    tick(3);
    check_val("fcs", `FSAC_FCS_RESET, fcs);
    check_val("mode_rst", FSAC_MODE_APP, mode);
    check_val("pin_rst", 16'h1, pin_en);
    t_link();
    t_app();
    t_protect();
    t_test_mode();
    finish_test();
  end
endmodule // testbench
